// file: logic/scrq_top.sv
// Purpose: Sync control, requantizer control and tuning registers for four channels
// Assumes: Register accesses arrive decoded from the serial control port, one cycle each
// Notes:   Local registers read back from the lowest selected channel
//
// Function
// - Divider sync passes when both enables set
// - Master enable clear disables all sync
// - Override bit picks pin or register control
// - Local writes reach only selected channels
// - Bandwidth code 000 is 22%, 001 33%
// - Enable bit obeyed only under override
// - Six-bit tuning word, resets to 0x1C
// - 57 tuning words at 22%, 34 at 33%
// - Each tuning step moves band 0.5%
`timescale 1ns/1ps
`include "scrq_regs.svh"

module scrq_top
  import scrq_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  scrq_reg_req_t               reg_req,
  input  wire logic [3:0]             chan_select,
  input  wire logic                   sync_in,
  input  wire logic                   mode_pin,
  output logic      [7:0]             reg_rdata,
  output logic                        reg_rvalid,
  output logic                        divider_sync,
  output logic                        sync_powered,
  output scrq_chan_stat_t [3:0]       chan_stat
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Lowest selected channel, channel 0 when none selected
  function automatic logic [1:0] first_chan(input logic [3:0] sel);
    logic [1:0] idx;
    idx = 2'd0;
    for (int i = 3; i >= 0; i--) begin
      if (sel[i]) idx = 2'(i);
    end
    return idx;
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire hit_sync = reg_req.addr == `SCRQ_ADDR_SYNC;
  wire hit_ctrl = reg_req.addr == `SCRQ_ADDR_CTRL;
  wire hit_tune = reg_req.addr == `SCRQ_ADDR_TUNE;
  wire wr_sync  = reg_req.wr && hit_sync;
  wire wr_ctrl  = reg_req.wr && hit_ctrl;
  wire wr_tune  = reg_req.wr && hit_tune;

  logic [7:0] sync_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       dsync_reg;
  logic [7:0] ctrl_q [`SCRQ_NCHAN];
  logic [7:0] tune_q [`SCRQ_NCHAN];

  wire master_en = sync_reg[`SCRQ_SYNC_MASTER_BIT];
  wire div_en    = sync_reg[`SCRQ_SYNC_DIV_BIT];
  wire [1:0] rd_ch = first_chan(chan_select);

  // ----------------------------------------------------------------
  // Per-channel local registers
  // ----------------------------------------------------------------
  // Unselected channels see no strobe and keep their settings
  for (genvar c = 0; c < `SCRQ_NCHAN; c++) begin : g_chan
    scrq_chan_ctrl u_chan (
      .clk      (clk),
      .rst      (rst),
      .wr_ctrl  (wr_ctrl && chan_select[c]),
      .wr_tune  (wr_tune && chan_select[c]),
      .wdata    (reg_req.wdata),
      .mode_pin (mode_pin),
      .ctrl_q   (ctrl_q[c]),
      .tune_q   (tune_q[c]),
      .stat     (chan_stat[c])
    );
  end

  // ----------------------------------------------------------------
  // Read mux; unmapped offsets read zero
  // ----------------------------------------------------------------
  always_comb begin
    if (hit_sync) begin
      rdata_next = sync_reg;
    end else if (hit_ctrl) begin
      rdata_next = ctrl_q[rd_ch];
    end else if (hit_tune) begin
      rdata_next = tune_q[rd_ch];
    end else begin
      rdata_next = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Global sync register and read path
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_reg   <= `SCRQ_SYNC_RESET;
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      if (wr_sync) sync_reg <= reg_req.wdata & `SCRQ_SYNC_MASK;
      rvalid_reg <= reg_req.rd;
      if (reg_req.rd) rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Sync gate to the clock divider
  // ----------------------------------------------------------------
  // Gate both enables so a stray divider bit cannot sync with master off
  always_ff @(posedge clk) begin
    if (rst) begin
      dsync_reg <= 1'b0;
    end else begin
      dsync_reg <= sync_in && master_en && div_en;
    end
  end

  assign divider_sync = dsync_reg;
  assign sync_powered = master_en;
  assign reg_rdata    = rdata_reg;
  assign reg_rvalid   = rvalid_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sync_gate_a: assert property (@(posedge clk) disable iff (rst)
    (sync_in && master_en && div_en) |=> divider_sync)
    else $error("sync pulse not passed");
  master_off_a: assert property (@(posedge clk) disable iff (rst)
    !master_en [*2] |-> !divider_sync && !sync_powered)
    else $error("sync active with master off");
  local_sel_a: assert property (@(posedge clk) disable iff (rst)
    (wr_ctrl && !chan_select[0]) |=> ctrl_q[0] == $past(ctrl_q[0]))
    else $error("unselected channel changed");
  local_wr_a: assert property (@(posedge clk) disable iff (rst)
    (wr_tune && chan_select[1]) |=> tune_q[1] == ($past(reg_req.wdata) & `SCRQ_TUNE_MASK))
    else $error("selected channel not written");
  bw_decode_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_q[0][`SCRQ_CTRL_BW_MSB:`SCRQ_CTRL_BW_LSB] == `SCRQ_BW_CODE_33 |=> chan_stat[0].bw33)
    else $error("33 percent code not decoded");
  tune_reset_a: assert property (@(posedge clk)
    $past(rst) |-> tune_q[2] == `SCRQ_TUNE_RESET)
    else $error("tuning word reset wrong");
  reserved_rd_a: assert property (@(posedge clk) disable iff (rst)
    (reg_req.rd && hit_sync) |=> reg_rvalid && reg_rdata[7:2] == 6'h00)
    else $error("reserved sync bits read nonzero");
  unmapped_rd_a: assert property (@(posedge clk) disable iff (rst)
    (reg_req.rd && !hit_sync && !hit_ctrl && !hit_tune) |=> reg_rdata == 8'h00)
    else $error("unmapped read nonzero");
  ctrl_rd_a: assert property (@(posedge clk) disable iff (rst)
    (reg_req.rd && hit_ctrl) |=> reg_rvalid && reg_rdata[7:5] == 3'h0)
    else $error("reserved control bits read nonzero");
  tune_rd_a: assert property (@(posedge clk) disable iff (rst)
    (reg_req.rd && hit_tune) |=> reg_rvalid && reg_rdata[7:6] == 2'h0)
    else $error("reserved tuning bits read nonzero");
  sync_store_a: assert property (@(posedge clk) disable iff (rst)
    wr_sync |=> sync_reg == ($past(reg_req.wdata) & `SCRQ_SYNC_MASK))
    else $error("sync register write wrong");
  tune_back_a: assert property (@(posedge clk) disable iff (rst)
    (reg_req.rd && hit_tune) |=> reg_rdata == $past(tune_q[rd_ch]))
    else $error("tuning word read back wrong");

  // Each gate input alone must block the pulse; a stuck input shows up here
  div_off_a: assert property (@(posedge clk) disable iff (rst)
    !div_en |=> !divider_sync)
    else $error("sync passed with divider enable off");
  master_gate_a: assert property (@(posedge clk) disable iff (rst)
    !master_en |=> !divider_sync)
    else $error("sync passed with master enable off");
  no_pulse_a: assert property (@(posedge clk) disable iff (rst)
    !sync_in |=> !divider_sync)
    else $error("divider sync without input pulse");

  // ----------------------------------------------------------------
  // Per-channel checks
  // ----------------------------------------------------------------
  // One block per channel so a fault in any lane is caught, not only in lane 0
  for (genvar c = 0; c < `SCRQ_NCHAN; c++) begin : g_chk
    chan_keep_a: assert property (@(posedge clk) disable iff (rst)
      ((wr_ctrl || wr_tune) && !chan_select[c])
        |=> ctrl_q[c] == $past(ctrl_q[c]) && tune_q[c] == $past(tune_q[c]))
      else $error("unselected channel register changed");
    chan_take_a: assert property (@(posedge clk) disable iff (rst)
      (wr_ctrl && chan_select[c]) |=> ctrl_q[c] == ($past(reg_req.wdata) & `SCRQ_CTRL_MASK))
      else $error("selected channel control not written");
    chan_reset_a: assert property (@(posedge clk)
      $past(rst) |-> tune_q[c] == `SCRQ_TUNE_RESET && ctrl_q[c] == `SCRQ_CTRL_RESET)
      else $error("channel register reset wrong");
    // Wide band only for code 001; the plain 22 % code must never select it
    chan_bw_a: assert property (@(posedge clk) disable iff (rst)
      (ctrl_q[c][`SCRQ_CTRL_BW_MSB:`SCRQ_CTRL_BW_LSB] == `SCRQ_BW_CODE_33) |=> chan_stat[c].bw33)
      else $error("wide band code not decoded");
    chan_narrow_a: assert property (@(posedge clk) disable iff (rst)
      (ctrl_q[c][`SCRQ_CTRL_BW_MSB:`SCRQ_CTRL_BW_LSB] == `SCRQ_BW_CODE_22) |=> !chan_stat[c].bw33)
      else $error("narrow band code not decoded");
    chan_clamp_a: assert property (@(posedge clk) disable iff (rst)
      (!chan_stat[c].bw33 && chan_stat[c].tune > `SCRQ_TW_MAX_22) |-> 1'b0)
      else $error("narrow band tuning word past limit");
    // Active source follows the override bit of the same channel
    chan_pin_a: assert property (@(posedge clk) disable iff (rst)
      !ctrl_q[c][`SCRQ_CTRL_OVR_BIT] |=> chan_stat[c].active == $past(mode_pin))
      else $error("channel active does not follow mode pin");
    chan_reg_a: assert property (@(posedge clk) disable iff (rst)
      ctrl_q[c][`SCRQ_CTRL_OVR_BIT] |=> chan_stat[c].active == $past(ctrl_q[c][`SCRQ_CTRL_EN_BIT]))
      else $error("channel active does not follow enable bit");
    chan_edge_a: assert property (@(posedge clk) disable iff (rst)
      chan_stat[c].edge_lo == {2'b00, chan_stat[c].tune})
      else $error("lower band edge not on tuning step");
  end

endmodule

// file: logic/scrq_regs.svh
// Purpose: Offsets, field positions, reset values and band figures for sync and requantizer control
// Assumes: 8-bit register data, 8-bit register addresses
// Notes:   Definitions only
`ifndef SCRQ_REGS_SVH
`define SCRQ_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SCRQ_ADDR_SYNC   8'h3A
`define SCRQ_ADDR_CTRL   8'h3C
`define SCRQ_ADDR_TUNE   8'h3E

// ----------------------------------------------------------------
// Writable-bit masks and reset values
// ----------------------------------------------------------------
`define SCRQ_SYNC_MASK   8'h03
`define SCRQ_CTRL_MASK   8'h1F
`define SCRQ_TUNE_MASK   8'h3F
`define SCRQ_SYNC_RESET  8'h00
`define SCRQ_CTRL_RESET  8'h00
`define SCRQ_TUNE_RESET  8'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCRQ_SYNC_MASTER_BIT 0
`define SCRQ_SYNC_DIV_BIT    1
`define SCRQ_CTRL_EN_BIT     0
`define SCRQ_CTRL_BW_LSB     1
`define SCRQ_CTRL_BW_MSB     3
`define SCRQ_CTRL_OVR_BIT    4

// ----------------------------------------------------------------
// Bandwidth codes, tuning limits and band spans (units of 0.5 %)
// ----------------------------------------------------------------
`define SCRQ_BW_CODE_22  3'h0
`define SCRQ_BW_CODE_33  3'h1
`define SCRQ_TW_MAX_22   6'h38
`define SCRQ_TW_MAX_33   6'h21
`define SCRQ_SPAN_22     8'h2C
`define SCRQ_SPAN_33     8'h42
`define SCRQ_NCHAN       4

`endif

// file: logic/scrq_pkg.sv
// Purpose: Types shared by the sync and requantizer control block
// Assumes: Constants come from scrq_regs.svh
// Notes:   Types only
package scrq_pkg;

  // ----------------------------------------------------------------
  // Register access from the serial control port engine
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scrq_reg_req_t;

  // ----------------------------------------------------------------
  // Per-channel requantizer state seen by the datapath
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       active;   // Requantizer in use
    logic       bw33;     // 1 = 33 % band, 0 = 22 % band
    logic [5:0] tune;     // Tuning word after range limit
    logic [7:0] edge_lo;  // Lower band edge, 0.5 % steps
    logic [7:0] edge_hi;  // Upper band edge, 0.5 % steps
  } scrq_chan_stat_t;

endpackage

// file: logic/scrq_chan_ctrl.sv
// Purpose: One channel's requantizer control and tuning registers with decoded band
// Assumes: Write strobes already qualified by channel selection
// Notes:   Status outputs are registered
`timescale 1ns/1ps
`include "scrq_regs.svh"

module scrq_chan_ctrl
  import scrq_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            wr_ctrl,
  input  wire logic            wr_tune,
  input  wire logic [7:0]      wdata,
  input  wire logic            mode_pin,
  output logic      [7:0]      ctrl_q,
  output logic      [7:0]      tune_q,
  output scrq_chan_stat_t      stat
);

  logic [7:0]      ctrl_reg;
  logic [7:0]      tune_reg;
  scrq_chan_stat_t stat_reg;
  scrq_chan_stat_t stat_next;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Only code 001 picks the wide band; other codes fall back to 22 %
  wire       bw33_w   = ctrl_reg[`SCRQ_CTRL_BW_MSB:`SCRQ_CTRL_BW_LSB] == `SCRQ_BW_CODE_33;
  wire [5:0] tw_max_w = bw33_w ? `SCRQ_TW_MAX_33 : `SCRQ_TW_MAX_22;
  wire [5:0] tw_w     = (tune_reg[5:0] > tw_max_w) ? tw_max_w : tune_reg[5:0];
  wire [7:0] span_w   = bw33_w ? `SCRQ_SPAN_33 : `SCRQ_SPAN_22;
  // Register enable counts only while the pin is overridden
  wire       act_w    = ctrl_reg[`SCRQ_CTRL_OVR_BIT] ? ctrl_reg[`SCRQ_CTRL_EN_BIT] : mode_pin;

  always_comb begin
    stat_next.active  = act_w;
    stat_next.bw33    = bw33_w;
    stat_next.tune    = tw_w;
    stat_next.edge_lo = {2'b00, tw_w};
    stat_next.edge_hi = {2'b00, tw_w} + span_w;
  end

  // ----------------------------------------------------------------
  // Registers; reserved bits never stored
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= `SCRQ_CTRL_RESET;
      tune_reg <= `SCRQ_TUNE_RESET;
      stat_reg <= '0;
    end else begin
      if (wr_ctrl) ctrl_reg <= wdata & `SCRQ_CTRL_MASK;
      if (wr_tune) tune_reg <= wdata & `SCRQ_TUNE_MASK;
      stat_reg <= stat_next;
    end
  end

  assign ctrl_q = ctrl_reg;
  assign tune_q = tune_reg;
  assign stat   = stat_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Status holds its reset image for one cycle after release, so skip that cycle
  pin_select_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) && !$past(ctrl_reg[`SCRQ_CTRL_OVR_BIT]) |-> stat.active == $past(mode_pin))
    else $error("active does not follow mode pin");
  reg_enable_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) && $past(ctrl_reg[`SCRQ_CTRL_OVR_BIT]) |-> stat.active == $past(ctrl_reg[`SCRQ_CTRL_EN_BIT]))
    else $error("active does not follow enable bit");
  tune_range_a: assert property (@(posedge clk) disable iff (rst)
    stat.tune <= (stat.bw33 ? `SCRQ_TW_MAX_33 : `SCRQ_TW_MAX_22))
    else $error("tuning word out of range");
  band_span_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> stat.edge_hi - stat.edge_lo == (stat.bw33 ? `SCRQ_SPAN_33 : `SCRQ_SPAN_22))
    else $error("band span wrong");

endmodule

// file: tb/scrq_host.sv
// Purpose: Serial control port host model issuing register accesses
// Assumes: One-cycle strobes, sampled on the rising edge
// Notes:   Address and data are scrambled once the strobe is released
`timescale 1ns/1ps
module scrq_host
  import scrq_pkg::*;
(
  input  wire logic       clk,
  output scrq_reg_req_t   req,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  initial req = '0;

  // One strobe per access, then back to idle so the port stays quiet
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'($urandom)};
  endtask

  // Bounded wait for the one-cycle valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    access(1'b0, a, 8'h00);
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      ok = reg_ok(rvalid);
      d = rdata;
      if (!ok) @(posedge clk);
    end
  endtask

  function automatic logic reg_ok(logic v);
    return v === 1'b1;
  endfunction
endmodule

// file: tb/scrq_top_tb.sv
// Purpose: Self-checking bench for the sync and requantizer control block
// Assumes: Host model drives the register port
// Notes:   Reference model kept in arrays, compared on every read and at each status check
`timescale 1ns/1ps
`include "scrq_regs.svh"
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin num_errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end
module scrq_top_tb
  import scrq_pkg::*;
;
  logic                  clk, rst, sync_in, mode_pin, divider_sync, sync_powered, reg_rvalid, ok;
  logic [3:0]            chan_select;
  logic [7:0]            reg_rdata, rd_v, sync_m, ctrl_m[4], tune_m[4];
  scrq_reg_req_t         reg_req;
  scrq_chan_stat_t [3:0] chan_stat;
  int                    num_errors, checks;
  logic [7:0]            adr[4] = '{`SCRQ_ADDR_SYNC, `SCRQ_ADDR_CTRL, `SCRQ_ADDR_TUNE, 8'h3B};

  scrq_top dut_u (.clk(clk), .rst(rst), .reg_req(reg_req), .chan_select(chan_select), .sync_in(sync_in),
    .mode_pin(mode_pin), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .divider_sync(divider_sync),
    .sync_powered(sync_powered), .chan_stat(chan_stat));
  scrq_host host_u (.clk(clk), .req(reg_req), .rdata(reg_rdata), .rvalid(reg_rvalid));

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  // Out-of-range words clamp to the last legal step of the mode
  function automatic scrq_chan_stat_t exp_stat(int c);
    int t, w;
    w = int'(ctrl_m[c][3:1] == `SCRQ_BW_CODE_33);
    t = int'(tune_m[c]);
    if (t > (w ? 33 : 56)) t = w ? 33 : 56;
    return '{active: ctrl_m[c][4] ? ctrl_m[c][0] : mode_pin, bw33: 1'(w), tune: 6'(t),
             edge_lo: 8'(t), edge_hi: 8'(t + (w ? 66 : 44))};
  endfunction

  function automatic int low();
    for (int c = 0; c < 4; c++) if (chan_select[c]) return c;
    return 0;
  endfunction

  task automatic wr(logic [7:0] a, logic [7:0] d);
    host_u.access(1'b1, a, d);
    for (int c = 0; c < 4; c++) if (chan_select[c]) begin
      if (a == `SCRQ_ADDR_CTRL) ctrl_m[c] = d & `SCRQ_CTRL_MASK;
      if (a == `SCRQ_ADDR_TUNE) tune_m[c] = d & `SCRQ_TUNE_MASK;
    end
    if (a == `SCRQ_ADDR_SYNC) sync_m = d & `SCRQ_SYNC_MASK;
  endtask

  task automatic rd_chk(logic [7:0] a);
    logic [7:0] e;
    e = a == `SCRQ_ADDR_SYNC ? sync_m : a == `SCRQ_ADDR_CTRL ? ctrl_m[low()] :
        a == `SCRQ_ADDR_TUNE ? tune_m[low()] : 8'h00;
    host_u.rd(a, rd_v, ok);
    if (!ok) begin
      num_errors++;
      report_and_stop();
    end
    `CHK("reg_rdata", e, rd_v)
  endtask

  task automatic stat_chk();
    for (int c = 0; c < 4; c++) `CHK("chan_stat", exp_stat(c), chan_stat[c])
  endtask

  task automatic report_and_stop();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rst = 1;
    sync_in = 0;
    mode_pin = 0;
    chan_select = 4'h1;
    num_errors = 0;
    checks = 0;
    sync_m = `SCRQ_SYNC_RESET;
    for (int c = 0; c < 4; c++) begin
      ctrl_m[c] = `SCRQ_CTRL_RESET;
      tune_m[c] = `SCRQ_TUNE_RESET;
    end
    void'($urandom(32'h93ED678A));
    repeat (4) @(posedge clk);
    rst <= 0;
    // Reset values, then an unmapped offset that must read zero
    foreach (adr[i]) rd_chk(adr[i]);
    stat_chk();
    // Every enable combination, reserved bits set; one sync pulse each
    for (int k = 0; k < 4; k++) begin
      wr(`SCRQ_ADDR_SYNC, 8'(k) | 8'hFC);
      rd_chk(`SCRQ_ADDR_SYNC);
      `CHK("sync_powered", 1'(k), sync_powered)
      @(posedge clk);
      sync_in <= 1;
      @(posedge clk);
      sync_in <= 0;
      #1 `CHK("divider_sync", 1'(k == 3), divider_sync)
      @(posedge clk);
      #1 `CHK("divider_sync", 1'b0, divider_sync)
    end
    // Random selections, modes and pin; tuning word sweeps every value
    for (int n = 0; n < 64; n++) begin
      @(posedge clk);
      chan_select <= 4'($urandom);
      mode_pin <= 1'($urandom);
      sync_in <= 1'($urandom);
      wr(`SCRQ_ADDR_CTRL, 8'($urandom));
      wr(`SCRQ_ADDR_TUNE, {2'($urandom), 6'(n)});
      rd_chk(adr[$urandom_range(3)]);
      stat_chk();
    end
    // Reset in mid-run: every register and status returns to its reset value
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    sync_m = `SCRQ_SYNC_RESET;
    for (int c = 0; c < 4; c++) begin
      ctrl_m[c] = `SCRQ_CTRL_RESET;
      tune_m[c] = `SCRQ_TUNE_RESET;
    end
    foreach (adr[i]) rd_chk(adr[i]);
    `CHK("sync_powered", 1'b0, sync_powered)
    stat_chk();
    // Sync logic left unpowered when not needed
    wr(`SCRQ_ADDR_SYNC, 8'h00);
    rd_chk(`SCRQ_ADDR_SYNC);
    report_and_stop();
  end
endmodule
